// ==== verilog/fmlog_regs.svh ====
// constants and rule summary for the fault memory logger
// Summary of operation
// R1: status 0 none, 1 inactive only, 2 active
// R2: diagnosis runs repeat continuously, not on request
// R3: detected fault stored as entry, marked active
// R4: active flag 1 if seen in latest run
// R5: flag 0 if not seen; entry kept until cleared
// R6: entries kept non-volatile; activity re-diagnosed after power
// R7: entries removed only by clear or firmware update
// R8: configuration download leaves entries unchanged
// R9: duration accumulates over all active periods
// R10: occurrence count equals number of active periods
// R11: entry keeps fault type and location codes
// R12: shared outputs step through stored entries periodically
// R13: after last entry, wrap to first entry
// R14: each entry shown for fixed dwell interval
// R15: duration and occurrence counters saturate
`ifndef FMLOG_REGS_SVH
`define FMLOG_REGS_SVH
`define FMLOG_OFF_CTRL 12'h000
`define FMLOG_OFF_STATUS 12'h004
`define FMLOG_OFF_ROTATE 12'h008
`define FMLOG_OFF_IRQ_STAT 12'h00C
`define FMLOG_OFF_IRQ_MASK 12'h010
`define FMLOG_OFF_RUN_PERIOD 12'h014
`define FMLOG_OFF_SEL 12'h018
`define FMLOG_OFF_ENTRY_CODE 12'h01C
`define FMLOG_OFF_ENTRY_DUR 12'h020
`define FMLOG_OFF_ENTRY_OCC 12'h024
`define FMLOG_CTRL_CLEAR 0
`define FMLOG_CTRL_FWUPD 1
`define FMLOG_IRQ_NEW 0
`define FMLOG_IRQ_ACTIVE 1
`define FMLOG_IRQ_FULL 2
`define FMLOG_RUN_PERIOD_RST 16'h0400
`define FMLOG_DWELL_MS 100
`define FMLOG_CLK_KHZ 50000
`define FMLOG_DWELL_CYC (`FMLOG_DWELL_MS * `FMLOG_CLK_KHZ)
`endif

// ==== verilog/fmlog_pkg.sv ====
// types for the fault memory logger
package fmlog_pkg;
  localparam int ENTRIES = 8;
  typedef logic [2:0] fmlog_idx_t;
  typedef logic [7:0] fmlog_code_t;
  typedef logic [31:0] fmlog_dur_t;
  typedef logic [15:0] fmlog_occ_t;
  typedef enum logic [1:0] {FMLOG_NONE, FMLOG_INACTIVE, FMLOG_ACTIVE} fmlog_status_e;
  typedef enum {FMLOG_IDLE, FMLOG_SCAN} fmlog_run_e;
endpackage

// ==== verilog/fmlog_rotator.sv ====
// rotating presentation of stored entries
`timescale 1ns/100ps
module fmlog_rotator #(
  parameter int DWELL_CYC = 5000000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] valid_map,
  output logic [2:0] sel_ff,
  output logic shown_ff
);
  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  logic [2:0] nxt_sel;
  logic nxt_shown;
  logic [2:0] cand;

  // dwell counter and search for next stored entry with wrap
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_sel = sel_ff;
    nxt_shown = valid_map[sel_ff];
    cand = sel_ff;
    if (cnt_ff >= DWELL_CYC - 1 || !valid_map[sel_ff]) begin // R14
      nxt_cnt = 32'h0;
      for (int i = 1; i <= 8; i++) begin
        cand = 3'(sel_ff + 3'(i)); // R13
        if (valid_map[cand] && nxt_sel == sel_ff && !(i == 8 && cnt_ff < DWELL_CYC - 1)) begin
          nxt_sel = cand; // R12
        end
      end
      nxt_shown = valid_map[nxt_sel];
    end else begin
      nxt_cnt = cnt_ff + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 32'h0;
      sel_ff <= 3'h0;
      shown_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      sel_ff <= nxt_sel;
      shown_ff <= nxt_shown;
    end
  end

  dwell_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cnt_ff != 32'h0 && valid_map[sel_ff]) |-> $stable(sel_ff) || cnt_ff == 32'h0) // R14
    else $error("entry left before dwell ended");
endmodule

// ==== verilog/fmlog_top.sv ====
// fault memory logger with apb register access
`timescale 1ns/100ps
`include "fmlog_regs.svh"
module fmlog_top #(
  parameter int DWELL_CYC = `FMLOG_DWELL_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fault_valid,
  input wire logic [7:0] fault_type,
  input wire logic [7:0] fault_location,
  output logic run_start,
  output logic [1:0] fault_status,
  output logic [7:0] rot_type,
  output logic [7:0] rot_location,
  output logic rot_active,
  output logic irq
);
  localparam int N = fmlog_pkg::ENTRIES;

  // entry storage; held in a retained power domain so entries outlive power loss
  logic [N-1:0] used_ff, act_ff, seen_ff;
  logic [N-1:0] nxt_used, nxt_act, nxt_seen;
  fmlog_pkg::fmlog_code_t type_ff [N];
  fmlog_pkg::fmlog_code_t loc_ff [N];
  fmlog_pkg::fmlog_dur_t dur_ff [N];
  fmlog_pkg::fmlog_occ_t occ_ff [N];
  fmlog_pkg::fmlog_code_t nxt_type [N];
  fmlog_pkg::fmlog_code_t nxt_loc [N];
  fmlog_pkg::fmlog_dur_t nxt_dur [N];
  fmlog_pkg::fmlog_occ_t nxt_occ [N];

  // run timing and registers
  fmlog_pkg::fmlog_run_e run_ff, nxt_run;
  logic [15:0] period_ff, nxt_period, runcnt_ff, nxt_runcnt;
  logic [2:0] irqst_ff, nxt_irqst, mask_ff, nxt_mask;
  logic [2:0] view_ff, nxt_view;
  logic [31:0] prdata_ff, nxt_prdata;
  logic [1:0] status_ff, nxt_status;
  logic [7:0] rtype_ff, rloc_ff;
  logic ract_ff;
  logic [2:0] rsel;
  logic rshown;
  logic wr, rd, run_end, clr;
  logic [N-1:0] hit;
  logic [N-1:0] free_first;
  logic ev_new, ev_act, ev_full;
  int unsigned k;
  // marks that the retained store has been cleared once and holds known contents
  logic mem_ok_ff, nxt_mem_ok;

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign clr = wr && paddr == `FMLOG_OFF_CTRL && (pwdata[`FMLOG_CTRL_CLEAR] || pwdata[`FMLOG_CTRL_FWUPD]); // R7
  assign run_end = run_ff == fmlog_pkg::FMLOG_SCAN && runcnt_ff == 16'h0;
  assign run_start = run_ff == fmlog_pkg::FMLOG_IDLE && runcnt_ff == 16'h0;
  assign nxt_mem_ok = mem_ok_ff | clr;

  // match and free-slot search for the reporting checker
  always_comb begin
    hit = '0;
    free_first = '0;
    for (int i = 0; i < N; i++) begin
      hit[i] = used_ff[i] && type_ff[i] == fault_type && loc_ff[i] == fault_location;
    end
    for (int i = N - 1; i >= 0; i--) begin
      if (!used_ff[i]) begin
        free_first = '0;
        free_first[i] = 1'b1;
      end
    end
  end

  // entry update: detection, run close, clear
  always_comb begin
    nxt_used = used_ff;
    nxt_act = act_ff;
    nxt_seen = seen_ff;
    nxt_type = type_ff;
    nxt_loc = loc_ff;
    nxt_dur = dur_ff;
    nxt_occ = occ_ff;
    ev_new = 1'b0;
    ev_act = 1'b0;
    ev_full = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (act_ff[i] && dur_ff[i] != 32'hFFFFFFFF) begin
        nxt_dur[i] = dur_ff[i] + 32'h1; // R9 R15
      end
    end
    if (fault_valid && run_ff == fmlog_pkg::FMLOG_SCAN) begin
      if (|hit) begin
        nxt_seen = seen_ff | hit;
        for (int i = 0; i < N; i++) begin
          if (hit[i] && !act_ff[i]) begin
            nxt_act[i] = 1'b1; // R4
            ev_act = 1'b1;
            if (occ_ff[i] != 16'hFFFF) nxt_occ[i] = occ_ff[i] + 16'h1; // R10 R15
          end
        end
      end else if (|free_first) begin
        ev_new = 1'b1;
        for (int i = 0; i < N; i++) begin
          if (free_first[i]) begin
            nxt_used[i] = 1'b1; // R3
            nxt_act[i] = 1'b1;
            nxt_seen[i] = 1'b1;
            nxt_type[i] = fault_type; // R11
            nxt_loc[i] = fault_location;
            nxt_dur[i] = 32'h0;
            nxt_occ[i] = 16'h1;
          end
        end
      end else begin
        ev_full = 1'b1;
      end
    end
    if (run_end) begin
      nxt_act = nxt_seen; // R5
      nxt_seen = '0;
    end
    if (clr) begin
      nxt_used = '0; // R7 R8
      nxt_act = '0;
      nxt_seen = '0;
    end
  end

  // diagnostic run sequencer: repeats forever
  always_comb begin
    nxt_run = run_ff;
    nxt_runcnt = runcnt_ff - 16'h1;
    if (runcnt_ff == 16'h0) begin
      nxt_run = run_ff == fmlog_pkg::FMLOG_IDLE ? fmlog_pkg::FMLOG_SCAN : fmlog_pkg::FMLOG_IDLE; // R2
      nxt_runcnt = period_ff;
    end
  end

  // summary status from stored entries
  always_comb begin
    if (|(act_ff & used_ff)) nxt_status = 2'(fmlog_pkg::FMLOG_ACTIVE); // R1
    else if (|used_ff) nxt_status = 2'(fmlog_pkg::FMLOG_INACTIVE);
    else nxt_status = 2'(fmlog_pkg::FMLOG_NONE);
  end

  // software registers, sticky interrupts and read mux
  always_comb begin
    nxt_period = period_ff;
    nxt_mask = mask_ff;
    nxt_view = view_ff;
    nxt_irqst = irqst_ff;
    nxt_prdata = prdata_ff;
    if (wr && paddr == `FMLOG_OFF_IRQ_STAT) nxt_irqst = irqst_ff & ~pwdata[2:0];
    if (wr && paddr == `FMLOG_OFF_IRQ_MASK) nxt_mask = pwdata[2:0];
    if (wr && paddr == `FMLOG_OFF_RUN_PERIOD) nxt_period = pwdata[15:0];
    if (wr && paddr == `FMLOG_OFF_SEL) nxt_view = pwdata[2:0];
    nxt_irqst[`FMLOG_IRQ_NEW] = nxt_irqst[`FMLOG_IRQ_NEW] | ev_new;
    nxt_irqst[`FMLOG_IRQ_ACTIVE] = nxt_irqst[`FMLOG_IRQ_ACTIVE] | ev_act;
    nxt_irqst[`FMLOG_IRQ_FULL] = nxt_irqst[`FMLOG_IRQ_FULL] | ev_full;
    k = 32'(view_ff);
    if (rd) begin
      case (paddr)
        `FMLOG_OFF_CTRL: nxt_prdata = 32'h0;
        `FMLOG_OFF_STATUS: nxt_prdata = {22'h0, used_ff, status_ff};
        `FMLOG_OFF_ROTATE: nxt_prdata = {15'h0, ract_ff, rloc_ff, rtype_ff};
        `FMLOG_OFF_IRQ_STAT: nxt_prdata = {29'h0, irqst_ff};
        `FMLOG_OFF_IRQ_MASK: nxt_prdata = {29'h0, mask_ff};
        `FMLOG_OFF_RUN_PERIOD: nxt_prdata = {16'h0, period_ff};
        `FMLOG_OFF_SEL: nxt_prdata = {29'h0, view_ff};
        `FMLOG_OFF_ENTRY_CODE: nxt_prdata = {14'h0, used_ff[k], act_ff[k], loc_ff[k], type_ff[k]};
        `FMLOG_OFF_ENTRY_DUR: nxt_prdata = dur_ff[k];
        `FMLOG_OFF_ENTRY_OCC: nxt_prdata = {16'h0, occ_ff[k]};
        default: nxt_prdata = 32'h0;
      endcase
    end
  end

  assign prdata = rd ? nxt_prdata : prdata_ff;
  assign pslverr = psel && penable && paddr > `FMLOG_OFF_ENTRY_OCC;
  assign irq = |(irqst_ff & mask_ff);
  assign fault_status = status_ff;
  assign rot_type = rtype_ff;
  assign rot_location = rloc_ff;
  assign rot_active = ract_ff;

  fmlog_rotator #(
    .DWELL_CYC(DWELL_CYC)
  ) u_rot (
    .pclk(pclk),
    .presetn(presetn),
    .valid_map(used_ff),
    .sel_ff(rsel),
    .shown_ff(rshown)
  );

  // entry store: no reset on contents, retained across power (R6 keeps act re-diagnosed)
  always_ff @(posedge pclk) begin
    type_ff <= nxt_type;
    loc_ff <= nxt_loc;
    dur_ff <= nxt_dur;
    occ_ff <= nxt_occ;
    used_ff <= nxt_used; // R6
    mem_ok_ff <= nxt_mem_ok;
  end

  // control state and outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_ff <= '0; // R6
      seen_ff <= '0;
      run_ff <= fmlog_pkg::FMLOG_IDLE;
      runcnt_ff <= 16'h0;
      period_ff <= `FMLOG_RUN_PERIOD_RST;
      mask_ff <= 3'h0;
      irqst_ff <= 3'h0;
      view_ff <= 3'h0;
      prdata_ff <= 32'h0;
      status_ff <= 2'h0;
      rtype_ff <= 8'h0;
      rloc_ff <= 8'h0;
      ract_ff <= 1'b0;
    end else begin
      act_ff <= nxt_act;
      seen_ff <= nxt_seen;
      run_ff <= nxt_run;
      runcnt_ff <= nxt_runcnt;
      period_ff <= nxt_period;
      mask_ff <= nxt_mask;
      irqst_ff <= nxt_irqst;
      view_ff <= nxt_view;
      prdata_ff <= nxt_prdata;
      status_ff <= nxt_status;
      rtype_ff <= rshown ? type_ff[rsel] : 8'h0; // R12
      rloc_ff <= rshown ? loc_ff[rsel] : 8'h0;
      ract_ff <= rshown && act_ff[rsel];
    end
  end

  status_active_a: assert property (@(posedge pclk) disable iff (!presetn)
    |(act_ff & used_ff) |=> status_ff == 2'h2) // R1
    else $error("status not 2 with active entry");
  status_empty_a: assert property (@(posedge pclk) disable iff (!presetn)
    (used_ff == '0) |=> status_ff == 2'h0) // R1
    else $error("status not 0 with empty memory");
  run_repeat_a: assert property (@(posedge pclk) disable iff (!presetn)
    run_end |=> run_ff == fmlog_pkg::FMLOG_IDLE) // R2
    else $error("run sequencer stalled");
  store_new_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ev_new && !clr && !run_end) |=> |(used_ff & act_ff & ~$past(used_ff))) // R3
    else $error("new fault not stored active");
  inactive_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
    (run_end && !clr && !fault_valid) |=> act_ff == $past(seen_ff)) // R5
    else $error("active flags not set from last run");
  clear_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mem_ok_ff && !clr) |=> (($past(used_ff) & ~used_ff) == '0)) // R7
    else $error("entry lost without clear");
  occ_sat_a: assert property (@(posedge pclk) disable iff (!presetn)
    (used_ff[0] && occ_ff[0] == 16'hFFFF && !clr && !ev_new) |=> occ_ff[0] == 16'hFFFF) // R15
    else $error("occurrence counter wrapped");
  dur_grow_a: assert property (@(posedge pclk) disable iff (!presetn)
    (act_ff[0] && dur_ff[0] != 32'hFFFFFFFF && !ev_new) |=> dur_ff[0] == $past(dur_ff[0]) + 32'h1) // R9
    else $error("duration did not accumulate");
endmodule

// ==== tb/fmlog_diag_model.sv ====
// diagnostic checker model reporting up to two faults at the start of each scan
`timescale 1ns/100ps
module fmlog_diag_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run_start,
  input wire logic a_on,
  input wire logic [7:0] a_type,
  input wire logic [7:0] a_loc,
  input wire logic b_on,
  input wire logic [7:0] b_type,
  input wire logic [7:0] b_loc,
  output logic fault_valid,
  output logic [7:0] fault_type,
  output logic [7:0] fault_location
);
  logic [1:0] step;
  logic [15:0] last;
  // step 1 reports slot a, step 2 slot b, then the model goes quiet until the next scan
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step <= 2'h0;
      last <= 16'h0000;
    end else begin
      step <= run_start ? 2'h1 : (step == 2'h2 ? 2'h0 : step + {1'b0, step != 2'h0});
      last <= {fault_type, fault_location};
    end
  end
  // codes show a changing pattern while nothing is reported
  assign fault_valid = (step == 2'h1 && a_on) || (step == 2'h2 && b_on);
  assign {fault_type, fault_location} = (step == 2'h1 && a_on) ? {a_type, a_loc} :
                                        (step == 2'h2 && b_on) ? {b_type, b_loc} : ~last;
endmodule

// ==== tb/fmlog_top_tb.sv ====
// self-checking bench for the fault memory logger
`timescale 1ns/100ps
`include "fmlog_regs.svh"
module fmlog_top_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, q, d1;
  logic pready, pslverr, e, fault_valid, run_start, rot_active, irq, a_on = 1'b0, b_on = 1'b0, sa, sb;
  logic [7:0] fault_type, fault_location, rot_type, rot_location, t;
  logic [1:0] fault_status;
  int fails = 0, cmp_count = 0, cyc = 0, n;

  fmlog_top #(.DWELL_CYC(16)) i_fmlog_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fault_valid(fault_valid), .fault_type(fault_type), .fault_location(fault_location),
    .run_start(run_start), .fault_status(fault_status), .rot_type(rot_type),
    .rot_location(rot_location), .rot_active(rot_active), .irq(irq));

  fmlog_diag_model i_fmlog_diag_model (.pclk(pclk), .presetn(presetn), .run_start(run_start),
    .a_on(a_on), .a_type(8'h11), .a_loc(8'h03), .b_on(b_on), .b_type(8'h22), .b_loc(8'h05),
    .fault_valid(fault_valid), .fault_type(fault_type), .fault_location(fault_location));

  // clock and cycle ceiling
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      wrap_up();
    end
  end

  // compare one value against its expectation
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer: setup, access until pready
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [11:0] a);
    apb(1'b0, a, 32'h00000000);
  endtask

  // a run is two phases of nine cycles with the period set to 8
  task runs(input int k);
    repeat (k * 18 + 4) @(posedge pclk);
  endtask

  task wrap_up;
    if (fails == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    wr(`FMLOG_OFF_CTRL, 32'h00000001);
    wr(`FMLOG_OFF_RUN_PERIOD, 32'h00000008);
    wr(`FMLOG_OFF_IRQ_MASK, 32'h00000007);
    // the scan begun at reset release still uses the reset period
    repeat (1100) @(posedge pclk);
    rd(`FMLOG_OFF_STATUS);
    check(q, 32'h00000000);
    check({rot_active, rot_location, rot_type}, 32'h00000000);
    wr(`FMLOG_OFF_IRQ_STAT, 32'h00000007);
    a_on <= 1'b1;
    runs(3);
    rd(`FMLOG_OFF_STATUS);
    check(q, 32'h00000006);
    check(irq, 32'h00000001);
    wr(`FMLOG_OFF_SEL, 32'h00000000);
    rd(`FMLOG_OFF_ENTRY_CODE);
    check(q, 32'h00030311);
    rd(`FMLOG_OFF_ENTRY_OCC);
    check(q, 32'h00000001);
    wr(`FMLOG_OFF_IRQ_STAT, 32'h00000007);
    @(posedge pclk);
    check(irq, 32'h00000000);
    a_on <= 1'b0;
    runs(3);
    rd(`FMLOG_OFF_STATUS);
    check(q, 32'h00000005);
    rd(`FMLOG_OFF_ENTRY_DUR);
    d1 = q;
    check({31'h0, d1 != 32'h0}, 32'h00000001);
    wr(`FMLOG_OFF_RUN_PERIOD, 32'h00000008);
    runs(1);
    rd(`FMLOG_OFF_ENTRY_DUR);
    check(q, d1);
    rd(`FMLOG_OFF_ENTRY_CODE);
    check(q, 32'h00020311);
    a_on <= 1'b1;
    b_on <= 1'b1;
    runs(3);
    rd(`FMLOG_OFF_ENTRY_OCC);
    check(q, 32'h00000002);
    rd(`FMLOG_OFF_ENTRY_DUR);
    check({31'h0, q > d1}, 32'h00000001);
    check(irq, 32'h00000001);
    rd(`FMLOG_OFF_STATUS);
    check(q, 32'h0000000E);
    sa = 1'b0;
    sb = 1'b0;
    repeat (40) begin
      @(posedge pclk);
      if (rot_type === 8'h11 && rot_location === 8'h03 && rot_active === 1'b1) sa = 1'b1;
      if (rot_type === 8'h22 && rot_location === 8'h05 && rot_active === 1'b1) sb = 1'b1;
    end
    check({sa, sb}, 32'h00000003);
    for (int i = 0; i < 2; i++) begin
      t = rot_type;
      n = 0;
      while (rot_type === t && n < 100) begin
        @(posedge pclk);
        n++;
      end
    end
    check(n, 32'h00000010);
    presetn <= 1'b0;
    a_on <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(`FMLOG_OFF_STATUS);
    check(q, 32'h0000000D);
    repeat (1200) @(posedge pclk);
    rd(`FMLOG_OFF_STATUS);
    check(q, 32'h0000000E);
    wr(`FMLOG_OFF_SEL, 32'h00000001);
    rd(`FMLOG_OFF_ENTRY_CODE);
    check(q, 32'h00030522);
    b_on <= 1'b0;
    wr(`FMLOG_OFF_CTRL, 32'h00000002);
    runs(1);
    rd(`FMLOG_OFF_STATUS);
    check(q, 32'h00000000);
    rd(12'h028);
    check(q, 32'h00000000);
    check(e, 32'h00000001);
    wrap_up();
  end
endmodule
